// ### src/bctu_cond_eval.sv
`timescale 1ns/1ps
`include "bctu_defs.svh"
module bctu_cond_eval
  import bctu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  bctu_link_if.eval lnk
);
  // ---------------------------------------------
  // condition evaluation
  // ---------------------------------------------
  bctu_eval_st_t st_ff;
  bctu_eval_st_t nxt_st;
  logic c, v, z, n, nxv; // flag shorthands

  // one decision per select
  always_comb begin
    c = lnk.ccr[`BCTU_CCR_C];
    v = lnk.ccr[`BCTU_CCR_V];
    z = lnk.ccr[`BCTU_CCR_Z];
    n = lnk.ccr[`BCTU_CCR_N];
    nxv = n ^ v; // signed relation term
    nxt_st = st_ff;
    // same table for short and wide forms
    unique case (lnk.cond)
      BCTU_ALWAYS: nxt_st.taken = 1'b1;
      BCTU_NEVER: nxt_st.taken = 1'b0;
      BCTU_CARRY_CLEAR: nxt_st.taken = ~c;
      BCTU_CARRY_SET: nxt_st.taken = c;
      BCTU_EQUAL: nxt_st.taken = z;
      BCTU_NOT_EQUAL: nxt_st.taken = ~z;
      BCTU_MINUS: nxt_st.taken = n;
      BCTU_PLUS: nxt_st.taken = ~n;
      BCTU_OVF_CLEAR: nxt_st.taken = ~v;
      BCTU_OVF_SET: nxt_st.taken = v;
      BCTU_U_HIGHER: nxt_st.taken = ~(c | z);
      BCTU_U_HIGHER_SAME: nxt_st.taken = ~c;
      BCTU_U_LOWER: nxt_st.taken = c; // wide form too, carry set
      BCTU_U_LOWER_SAME: nxt_st.taken = c | z;
      BCTU_S_GE: nxt_st.taken = ~nxv;
      BCTU_S_GT: nxt_st.taken = ~(z | nxv);
      BCTU_S_LE: nxt_st.taken = z | nxv;
      BCTU_S_LT: nxt_st.taken = nxv;
      // every masked bit one: inverted byte and mask is zero
      BCTU_BITS_SET: nxt_st.taken = ((~lnk.mem_byte) & lnk.mask) == 8'h00;
      // every masked bit zero
      BCTU_BITS_CLEAR: nxt_st.taken = (lnk.mem_byte & lnk.mask) == 8'h00;
      default: nxt_st.taken = 1'b0; // unused select codes never branch
    endcase
  end

  // decision register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.taken = st_ff.taken;
endmodule // bctu_cond_eval

// ### src/bctu_defs.svh
`ifndef BCTU_DEFS_SVH
`define BCTU_DEFS_SVH
// condition code bit positions in the ccr byte
`define BCTU_CCR_C 0
`define BCTU_CCR_V 1
`define BCTU_CCR_Z 2
`define BCTU_CCR_N 3
// reset values
`define BCTU_PC_RST 16'h0000
`define BCTU_OP_RST 8'h00
// condition select field width
`define BCTU_COND_W 5
`endif

// ### src/bctu_link_if.sv
`timescale 1ns/1ps
// carries a decoded branch from the top to its two helper modules
interface bctu_link_if;
  import bctu_pkg::*;
  bctu_cond_t cond; // selected condition
  logic [7:0] ccr; // condition code byte
  logic [7:0] mem_byte; // memory operand for bit tests
  logic [7:0] mask; // mask operand for bit tests
  logic taken; // registered decision
  bctu_disp_t disp_kind; // short or wide offset
  logic [15:0] disp; // raw displacement
  logic [15:0] next_pc; // address after the offset operand
  logic [15:0] taken_pc; // registered target
  logic [15:0] seq_pc; // registered fall-through
  modport top (output cond, ccr, mem_byte, mask, disp_kind, disp, next_pc,
               input taken, taken_pc, seq_pc);
  modport eval (input cond, ccr, mem_byte, mask, output taken);
  modport adder (input disp_kind, disp, next_pc, output taken_pc, seq_pc);
endinterface

// ### src/bctu_pkg.sv
package bctu_pkg;
  // -------------------------------------------------
  // branch condition selects
  // -------------------------------------------------
  typedef enum logic [4:0] {
    BCTU_ALWAYS = 5'h00,
    BCTU_NEVER = 5'h01,
    BCTU_CARRY_CLEAR = 5'h02,
    BCTU_CARRY_SET = 5'h03,
    BCTU_EQUAL = 5'h04,
    BCTU_NOT_EQUAL = 5'h05,
    BCTU_MINUS = 5'h06,
    BCTU_PLUS = 5'h07,
    BCTU_OVF_CLEAR = 5'h08,
    BCTU_OVF_SET = 5'h09,
    BCTU_U_HIGHER = 5'h0a,
    BCTU_U_HIGHER_SAME = 5'h0b,
    BCTU_U_LOWER = 5'h0c,
    BCTU_U_LOWER_SAME = 5'h0d,
    BCTU_S_GE = 5'h0e,
    BCTU_S_GT = 5'h0f,
    BCTU_S_LE = 5'h10,
    BCTU_S_LT = 5'h11,
    BCTU_BITS_SET = 5'h12,
    BCTU_BITS_CLEAR = 5'h13
  } bctu_cond_t;

  // displacement width kinds
  typedef enum logic [1:0] {
    BCTU_DISP_SHORT = 2'b01,
    BCTU_DISP_WIDE = 2'b10
  } bctu_disp_t;

  // top state machine, one-hot
  typedef enum logic [1:0] {
    BCTU_ST_IDLE = 2'b01,
    BCTU_ST_DONE = 2'b10
  } bctu_state_t;

  // state of the condition evaluator
  typedef struct packed {
    logic taken;
  } bctu_eval_st_t;

  // state of the target adder
  typedef struct packed {
    logic [15:0] taken_pc;
    logic [15:0] seq_pc;
  } bctu_add_st_t;

  // state of the top
  typedef struct packed {
    bctu_state_t state;
    logic valid;
    logic taken;
    logic [15:0] pc;
  } bctu_top_st_t;
endpackage

// ### src/branch_condition_target_unit.sv
`timescale 1ns/1ps
`include "bctu_defs.svh"

// -------------------------------------------------
// target adder
// -------------------------------------------------
module bctu_target_add
  import bctu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  bctu_link_if.adder lnk
);
  bctu_add_st_t st_ff;
  bctu_add_st_t nxt_st;
  logic [15:0] ext; // sign-extended offset

  // sign-extend an 8-bit offset
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction

  // offset extension and modulo add
  always_comb begin
    nxt_st = st_ff;
    // short kind uses the low byte; bit forms use it only when br_wide is low
    ext = (lnk.disp_kind == BCTU_DISP_WIDE) ? lnk.disp : sext8(lnk.disp[7:0]);
    // 16-bit sum drops carry out, wraps the map
    nxt_st.taken_pc = 16'(lnk.next_pc + ext);
    nxt_st.seq_pc = lnk.next_pc; // fall-through after encoding
  end

  // target register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.taken_pc = st_ff.taken_pc;
  assign lnk.seq_pc = st_ff.seq_pc;
endmodule // bctu_target_add

// -------------------------------------------------
// top
// -------------------------------------------------
module branch_condition_target_unit
  import bctu_pkg::*;
(
  input wire logic clk_sys, // core clock
  input wire logic rst_b, // sync reset, low
  input wire logic br_req, // one-cycle branch request
  input wire logic [4:0] br_cond, // condition select code
  input wire logic br_wide, // 1 = 16-bit offset
  input wire logic [15:0] br_disp, // offset operand
  input wire logic [15:0] br_next_pc, // address after offset operand
  input wire logic [7:0] ccr, // condition code byte
  input wire logic [7:0] mem_byte, // tested memory byte
  input wire logic [7:0] mask, // mask operand
  output logic res_valid, // one-cycle result strobe
  output logic res_taken, // branch was taken
  output logic [15:0] res_pc // next fetch address
);
  bctu_link_if lnk ();
  bctu_top_st_t st_ff;
  bctu_top_st_t nxt_st;

  // operands go straight to the helpers
  assign lnk.cond = bctu_cond_t'(br_cond);
  assign lnk.ccr = ccr;
  assign lnk.mem_byte = mem_byte;
  assign lnk.mask = mask;
  assign lnk.disp = br_disp;
  assign lnk.next_pc = br_next_pc;
  assign lnk.disp_kind = br_wide ? BCTU_DISP_WIDE : BCTU_DISP_SHORT;

  // condition evaluator
  bctu_cond_eval u_eval (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .lnk(lnk)
  );

  // target adder
  bctu_target_add u_add (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .lnk(lnk)
  );

  // sequencing: helpers register in cycle 1, result out in cycle 2
  always_comb begin
    nxt_st = st_ff;
    nxt_st.valid = 1'b0;
    unique case (st_ff.state)
      BCTU_ST_IDLE: begin
        if (br_req) begin
          nxt_st.state = BCTU_ST_DONE;
        end
      end
      BCTU_ST_DONE: begin
        nxt_st.state = BCTU_ST_IDLE;
        nxt_st.valid = 1'b1;
        nxt_st.taken = lnk.taken;
        // pick target or fall-through
        nxt_st.pc = lnk.taken ? lnk.taken_pc : lnk.seq_pc;
      end
      default: begin
        nxt_st.state = BCTU_ST_IDLE; // illegal code recovers
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_ff.state <= BCTU_ST_IDLE;
      st_ff.valid <= 1'b0;
      st_ff.taken <= 1'b0;
      st_ff.pc <= `BCTU_PC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign res_valid = st_ff.valid;
  assign res_taken = st_ff.taken;
  assign res_pc = st_ff.pc;
endmodule // branch_condition_target_unit

// ### verification/bctu_chk.sv
`timescale 1ns/1ps
module bctu_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic br_req,
  input wire logic [4:0] br_cond,
  input wire logic br_wide,
  input wire logic [15:0] br_disp,
  input wire logic [15:0] br_next_pc,
  input wire logic [7:0] ccr,
  input wire logic [7:0] mem_byte,
  input wire logic [7:0] mask,
  input wire logic res_valid,
  input wire logic res_taken,
  input wire logic [15:0] res_pc
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // request capture for result checks
  logic busy_ff, c_ff;
  logic [15:0] off_ff, npc_ff;
  wire logic acc = br_req && !busy_ff;
  always_ff @(posedge clk_sys) begin
    busy_ff <= rst_b && acc;
    if (acc) begin
      c_ff <= ccr[0];
      off_ff <= br_wide ? br_disp : {{8{br_disp[7]}}, br_disp[7:0]};
      npc_ff <= br_next_pc;
    end
  end
  property p_answer; acc |-> ##2 res_valid; endproperty
  a_answer: assert property (p_answer) else $error("no result");
  property p_pulse; res_valid |=> !res_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("long strobe");
  property p_hold; !res_valid |-> $stable(res_pc) && $stable(res_taken); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_always; acc && br_cond == 5'h00 |-> ##2 res_taken; endproperty
  a_always: assert property (p_always) else $error("always missed");
  property p_never; acc && br_cond == 5'h01 |-> ##2 !res_taken; endproperty
  a_never: assert property (p_never) else $error("never taken");
  property p_target; res_valid && res_taken |-> res_pc == npc_ff + off_ff; endproperty
  a_target: assert property (p_target) else $error("bad target");
  property p_fall; res_valid && !res_taken |-> res_pc == npc_ff; endproperty
  a_fall: assert property (p_fall) else $error("bad fall pc");
  property p_lower; acc && br_cond == 5'h0c |-> ##2 res_taken == c_ff; endproperty
  a_lower: assert property (p_lower) else $error("bad lower");
  property p_carry; acc && br_cond == 5'h03 |-> ##2 res_taken == c_ff; endproperty
  a_carry: assert property (p_carry) else $error("bad carry set");
endmodule // bctu_chk
bind branch_condition_target_unit bctu_chk u_chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .br_req(br_req),
  .br_cond(br_cond),
  .br_wide(br_wide),
  .br_disp(br_disp),
  .br_next_pc(br_next_pc),
  .ccr(ccr),
  .mem_byte(mem_byte),
  .mask(mask),
  .res_valid(res_valid),
  .res_taken(res_taken),
  .res_pc(res_pc)
);

// ### verification/bctu_dec_model.sv
`timescale 1ns/1ps
// decoder side: one request, operands held one cycle more, then all but br_cond and br_wide scrambled
module bctu_dec_model (
  input wire logic clk_sys,
  output logic br_req,
  output logic [4:0] br_cond,
  output logic br_wide,
  output logic [15:0] br_disp,
  output logic [15:0] br_next_pc,
  output logic [7:0] ccr,
  output logic [7:0] mem_byte,
  output logic [7:0] mask
);
  initial {br_req, br_cond, br_wide, br_disp, br_next_pc, ccr, mem_byte, mask} = '0;
  task automatic send(input logic [4:0] c, input logic w, input logic [15:0] d, n,
      input logic [7:0] f, m, k);
    @(posedge clk_sys);
    br_req <= 1'b1;
    {br_cond, br_wide, br_disp, br_next_pc, ccr, mem_byte, mask} <= {c, w, d, n, f, m, k};
    @(posedge clk_sys);
    br_req <= 1'b0;
    @(posedge clk_sys);
    {br_disp, br_next_pc, ccr, mem_byte, mask} <= ~{d, n, f, m, k};
  endtask
endmodule // bctu_dec_model

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import bctu_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic br_req, br_wide, res_valid, res_taken;
  logic [4:0] br_cond;
  logic [15:0] br_disp, br_next_pc, res_pc;
  logic [7:0] ccr, mem_byte, mask;
  int err_total = 0;
  int tests_run = 0;
  always #12.5 clk_sys = ~clk_sys;
  // decoder side partner
  bctu_dec_model u_dec (
    .clk_sys(clk_sys),
    .br_req(br_req),
    .br_cond(br_cond),
    .br_wide(br_wide),
    .br_disp(br_disp),
    .br_next_pc(br_next_pc),
    .ccr(ccr),
    .mem_byte(mem_byte),
    .mask(mask)
  );
  branch_condition_target_unit DUT (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .br_req(br_req),
    .br_cond(br_cond),
    .br_wide(br_wide),
    .br_disp(br_disp),
    .br_next_pc(br_next_pc),
    .ccr(ccr),
    .mem_byte(mem_byte),
    .mask(mask),
    .res_valid(res_valid),
    .res_taken(res_taken),
    .res_pc(res_pc)
  );
  // ---------------
  // expectations
  // ---------------
  function automatic logic exp_tk(logic [4:0] c, logic [7:0] f, m, k);
    logic n, z, v, cy;
    {n, z, v, cy} = f[3:0];
    case (c)
      5'h00: return 1'b1;
      5'h02, 5'h0b: return !cy;
      5'h03, 5'h0c: return cy;
      5'h04: return z;
      5'h05: return !z;
      5'h06: return n;
      5'h07: return !n;
      5'h08: return !v;
      5'h09: return v;
      5'h0a: return !(cy | z);
      5'h0d: return cy | z;
      5'h0e: return !(n ^ v);
      5'h0f: return !(z | (n ^ v));
      5'h10: return z | (n ^ v);
      5'h11: return n ^ v;
      5'h12: return (~m & k) == 8'h00;
      5'h13: return (m & k) == 8'h00;
      default: return 1'b0;
    endcase
  endfunction
  // single-bit result compare, unknowns count as mismatch
  task automatic check_bit(input logic got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic check(input logic [15:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one branch and its result
  task automatic run(input logic [4:0] c, input logic w, input logic [15:0] d, n,
      input logic [7:0] f, m, k);
    logic tk;
    logic [15:0] pc;
    tk = exp_tk(c, f, m, k);
    pc = tk ? n + (w ? d : {{8{d[7]}}, d[7:0]}) : n;
    u_dec.send(c, w, d, n, f, m, k);
    #1;
    check_bit(res_valid, 1'b1, "valid");
    check_bit(res_taken, tk, "taken");
    check(res_pc, pc, "pc");
    $display("test %0d done", tests_run);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hc5707f99));
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) for (int c = 0; c < 20; c++) for (int w = 0; w < 2; w++)
      run(5'(c), 1'(w) & (c < 18), 16'($urandom), 16'($urandom), 8'($urandom),
          8'($urandom), 8'($urandom));
    run(5'h00, 1'b0, 16'h0080, 16'h0010, 8'h00, 8'h00, 8'h00);
    run(5'h00, 1'b0, 16'hff7f, 16'hfff0, 8'h00, 8'h00, 8'h00);
    run(5'h00, 1'b1, 16'h8000, 16'h0002, 8'h00, 8'h00, 8'h00);
    run(5'h00, 1'b1, 16'h7fff, 16'hffff, 8'h00, 8'h00, 8'h00);
    run(5'h0c, 1'b1, 16'h0100, 16'h1000, 8'h04, 8'h00, 8'h00);
    run(5'h0c, 1'b1, 16'h0100, 16'h1000, 8'h01, 8'h00, 8'h00);
    run(5'h12, 1'b0, 16'h00f0, 16'h4000, 8'h00, 8'hf0, 8'hf0);
    run(5'h13, 1'b0, 16'h0012, 16'h4000, 8'h00, 8'h0f, 8'h00);
    run(5'h12, 1'b0, 16'h0012, 16'h4000, 8'h00, 8'h7f, 8'h81);
    run(5'h13, 1'b0, 16'h0012, 16'h4000, 8'h00, 8'h7e, 8'h81);
    run(5'h01, 1'b1, 16'h1234, 16'h5678, 8'hff, 8'h00, 8'h00);
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
endmodule // tb_top
